//--- common/crfp_consts.vh
// Constants for the execute unit register file with privilege checks
// Overview of operation
// - Thirty-two 32-bit registers: general, kernel, dedicated
// - Kernel-only writes to kernel, status, block pointer, interrupt stack
// - Privileged registers readable at every level
// - Program counter and status word mode-restricted
// - Working registers hidden from operand specifiers
// - Track four levels, kernel highest
// - Extend byte and halfword operands to 32
// - General registers open to all levels
// - Program counter holds current, then next address
`ifndef CRFP_CONSTS_VH
`define CRFP_CONSTS_VH
`define CRFP_REG_FRAME  5'h09
`define CRFP_REG_ARG    5'h0A
`define CRFP_REG_STATUS 5'h0B
`define CRFP_REG_SP     5'h0C
`define CRFP_REG_CBP    5'h0D
`define CRFP_REG_INTSTK 5'h0E
`define CRFP_REG_PC     5'h0F
`define CRFP_KERN_FIRST 5'h18
`define CRFP_LVL_KERNEL 2'h0
`define CRFP_LVL_EXEC   2'h1
`define CRFP_LVL_SUPER  2'h2
`define CRFP_LVL_USER   2'h3
`define CRFP_SIZE_BYTE  2'h0
`define CRFP_SIZE_HALF  2'h1
`define CRFP_SIZE_WORD  2'h2
`define CRFP_RESET_VAL  32'h00000000
`define CRFP_RESET_LVL  2'h0
`define CRFP_WK_COUNT   4
`endif

//--- logic/crfp_regfile.v
// Execute unit register file with privilege gating and operand extension
`timescale 1ns/1ps
`include "crfp_consts.vh"
module crfp_regfile #(
  parameter WK_COUNT = `CRFP_WK_COUNT
) (
  // Clock and reset
  input  wire        REF_CLK_I,
  input  wire        RST_N_I,
  // Execution level control
  input  wire        LVL_WE_I,
  input  wire [1:0]  LVL_I,
  // Operand read port
  input  wire [4:0]  RD_ADDR_I,
  input  wire        RD_RESTRICTED_MODE_I,
  output reg  [31:0] RD_DATA_O,
  output reg         RD_MODE_FAULT_O,
  // Operand write port with extension
  input  wire        WR_EN_I,
  input  wire [4:0]  WR_ADDR_I,
  input  wire [31:0] WR_DATA_I,
  input  wire [1:0]  WR_SIZE_I,
  input  wire        WR_SIGNED_I,
  // Program counter update at instruction completion
  input  wire        PC_LOAD_I,
  input  wire [31:0] PC_NEXT_I,
  // Working registers, sequencer only
  input  wire        WK_WE_I,
  input  wire [1:0]  WK_ADDR_I,
  input  wire [31:0] WK_WDATA_I,
  output reg  [31:0] WK_RDATA_O,
  // Status outputs
  output reg  [1:0]  LVL_O,
  output reg         PRIV_VIOL_O,
  output reg  [31:0] PC_O
);

  // Register count fixed by the architecture
  localparam NUM_REGS = 32;

  // Storage, index equals the register number
  reg  [31:0] regs [0:NUM_REGS-1];
  reg  [31:0] wk [0:WK_COUNT-1];

  // Write path
  reg  [31:0] byte_ext;
  reg  [31:0] half_ext;
  reg  [31:0] ext_data;
  reg         is_kernel;
  reg  [1:0]  next_lvl;
  wire        hit_kern_gen;
  wire        hit_status;
  wire        hit_cbp;
  wire        hit_intstk;
  wire        is_priv;
  wire        wr_ok;
  wire        next_viol;
  wire        wr_pc;

  // Read path
  wire        rd_hit_pc;
  wire        rd_hit_status;
  wire        next_mode_fault;
  wire [31:0] next_rd_data;
  wire [31:0] next_wk_rdata;
  wire [31:0] next_pc;
  integer     i;
  integer     k;

  // Gate reads the level flop itself, so port and gate never disagree
  // Only kernel opens the privileged set; the three lower levels are alike
  always @* begin
    case (LVL_O)
      `CRFP_LVL_KERNEL: begin
        is_kernel = 1'b1;
      end
      `CRFP_LVL_EXEC: begin
        is_kernel = 1'b0;
      end
      `CRFP_LVL_SUPER: begin
        is_kernel = 1'b0;
      end
      `CRFP_LVL_USER: begin
        is_kernel = 1'b0;
      end
      default: begin
        is_kernel = 1'b0;
      end
    endcase
  end

  // Privileged write targets
  assign hit_kern_gen = (WR_ADDR_I >= `CRFP_KERN_FIRST);
  assign hit_status   = (WR_ADDR_I == `CRFP_REG_STATUS);
  assign hit_cbp      = (WR_ADDR_I == `CRFP_REG_CBP);
  assign hit_intstk   = (WR_ADDR_I == `CRFP_REG_INTSTK);
  assign is_priv      = hit_kern_gen | hit_status | hit_cbp | hit_intstk;

  // Open registers pass at any level
  assign wr_ok     = WR_EN_I & (~is_priv | is_kernel);
  assign next_viol = WR_EN_I & is_priv & ~is_kernel;
  assign wr_pc     = wr_ok & (WR_ADDR_I == `CRFP_REG_PC);

  // Operand specifier restriction
  assign rd_hit_pc       = (RD_ADDR_I == `CRFP_REG_PC);
  assign rd_hit_status   = (RD_ADDR_I == `CRFP_REG_STATUS);
  assign next_mode_fault = RD_RESTRICTED_MODE_I & (rd_hit_pc | rd_hit_status);

  // Reads are never gated by level
  assign next_rd_data = regs[RD_ADDR_I];

  // Sequencer read-back only; no operand specifier decodes into this array
  assign next_wk_rdata = wk[WK_ADDR_I];

  // Completion load beats an operand write to the counter
  assign next_pc = PC_LOAD_I ? PC_NEXT_I : (wr_pc ? ext_data : regs[`CRFP_REG_PC]);

  // Byte and halfword extension before storing
  always @* begin
    byte_ext = {{24{WR_SIGNED_I & WR_DATA_I[7]}}, WR_DATA_I[7:0]};
    half_ext = {{16{WR_SIGNED_I & WR_DATA_I[15]}}, WR_DATA_I[15:0]};
    case (WR_SIZE_I)
      `CRFP_SIZE_BYTE: begin
        ext_data = byte_ext;
      end
      `CRFP_SIZE_HALF: begin
        ext_data = half_ext;
      end
      default: begin
        ext_data = WR_DATA_I;
      end
    endcase
  end

  // New level applies to writes from the following edge
  always @* begin
    next_lvl = LVL_O;
    if (LVL_WE_I) begin
      next_lvl = LVL_I;
    end
  end

  // Level register; reset enters kernel
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LVL_O <= `CRFP_RESET_LVL;
    end else begin
      LVL_O <= next_lvl;
    end
  end

  // Thirty-two user registers
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (i = 0; i < NUM_REGS; i = i + 1) begin
        regs[i] <= `CRFP_RESET_VAL;
      end
    end else begin
      if (wr_ok) begin
        regs[WR_ADDR_I] <= ext_data;
      end
      if (PC_LOAD_I) begin
        regs[`CRFP_REG_PC] <= PC_NEXT_I;
      end
    end
  end

  // Working registers for the sequencer alone
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (k = 0; k < WK_COUNT; k = k + 1) begin
        wk[k] <= `CRFP_RESET_VAL;
      end
    end else if (WK_WE_I) begin
      wk[WK_ADDR_I] <= WK_WDATA_I;
    end
  end

  // Read-back lags the address by one edge
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WK_RDATA_O <= `CRFP_RESET_VAL;
    end else begin
      WK_RDATA_O <= next_wk_rdata;
    end
  end

  // Operand read data
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_DATA_O <= `CRFP_RESET_VAL;
    end else begin
      RD_DATA_O <= next_rd_data;
    end
  end

  // Flag only; data still returned so the controller decides
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_MODE_FAULT_O <= 1'b0;
    end else begin
      RD_MODE_FAULT_O <= next_mode_fault;
    end
  end

  // One-cycle pulse per refused write
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRIV_VIOL_O <= 1'b0;
    end else begin
      PRIV_VIOL_O <= next_viol;
    end
  end

  // Counter copy on the port
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PC_O <= `CRFP_RESET_VAL;
    end else begin
      PC_O <= next_pc;
    end
  end

endmodule

//--- testbench/crfp_ctl_model.sv
// Controller model supplying the next instruction address
`timescale 1ns/1ps
module crfp_ctl_model (
  input  wire [31:0] pc_i,
  output wire [31:0] pc_next_o
);
  // Fixed 4-byte steps keep expectations simple
  assign pc_next_o = pc_i + 32'h00000004;
endmodule

//--- testbench/crfp_regfile_checker.sv
// Port assertions for the register file
`timescale 1ns/1ps
module crfp_regfile_checker (
  input wire        REF_CLK_I, RST_N_I, LVL_WE_I, WR_EN_I, PC_LOAD_I, PRIV_VIOL_O,
  input wire        RD_RESTRICTED_MODE_I, RD_MODE_FAULT_O,
  input wire [1:0]  LVL_I, LVL_O,
  input wire [4:0]  RD_ADDR_I, WR_ADDR_I,
  input wire [31:0] PC_NEXT_I, PC_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Privileged targets: kernel generals, status word, block pointer, interrupt stack
  wire bad = WR_EN_I && (LVL_O != 2'h0) &&
             ((WR_ADDR_I >= 5'h18) || (WR_ADDR_I == 5'h0B) || (WR_ADDR_I == 5'h0D) ||
              (WR_ADDR_I == 5'h0E));
  wire rsv = RD_RESTRICTED_MODE_I && (RD_ADDR_I == 5'h0F || RD_ADDR_I == 5'h0B);
  chk_viol_raise: assert property (bad |=> PRIV_VIOL_O) else $error("viol");
  chk_viol_quiet: assert property (!bad |=> !PRIV_VIOL_O) else $error("viol");
  chk_mode_fault: assert property (rsv |=> RD_MODE_FAULT_O) else $error("fault");
  chk_fault_quiet: assert property (!rsv |=> !RD_MODE_FAULT_O) else $error("fault");
  chk_pc_load: assert property (PC_LOAD_I |=> PC_O == $past(PC_NEXT_I)) else $error("pc");
  chk_pc_hold: assert property (!PC_LOAD_I && !WR_EN_I |=> $stable(PC_O)) else $error("pc");
  chk_lvl_load: assert property (LVL_WE_I |=> LVL_O == $past(LVL_I)) else $error("lvl");
  chk_lvl_hold: assert property (!LVL_WE_I |=> $stable(LVL_O)) else $error("lvl");
  cover property (bad);
  cover property (LVL_WE_I && LVL_I == 2'h3);
  cover property (rsv);
  cover property (PC_LOAD_I);
endmodule
bind crfp_regfile crfp_regfile_checker crfp_regfile_checker_inst (.*);

//--- testbench/tb_top.sv
// Self-checking bench for the privileged register file
`timescale 1ns/1ps
module tb_top;
  reg         c = 0, r = 0, lw = 0, rm = 0, we = 0, sg = 0, pl = 0, v;
  reg  [1:0]  l = 0, sz = 0;
  reg  [4:0]  ra = 0, wa = 0;
  reg  [31:0] wd = 0;
  wire [31:0] rd, pc, pn;
  wire        f, pv;
  wire [1:0]  lo;
  reg         kw = 0;
  reg  [1:0]  ka = 0;
  reg  [31:0] kd = 0;
  wire [31:0] wko;
  integer     err_count = 0, checked = 0, cy = 0;
  crfp_regfile crfp_regfile_inst (.REF_CLK_I(c), .RST_N_I(r), .LVL_WE_I(lw), .LVL_I(l),
    .RD_ADDR_I(ra), .RD_RESTRICTED_MODE_I(rm), .RD_DATA_O(rd), .RD_MODE_FAULT_O(f),
    .WR_EN_I(we), .WR_ADDR_I(wa), .WR_DATA_I(wd), .WR_SIZE_I(sz), .WR_SIGNED_I(sg),
    .PC_LOAD_I(pl), .PC_NEXT_I(pn), .WK_WE_I(kw), .WK_ADDR_I(ka), .WK_WDATA_I(kd),
    .WK_RDATA_O(wko), .LVL_O(lo), .PRIV_VIOL_O(pv), .PC_O(pc));
  crfp_ctl_model crfp_ctl_model_inst (.pc_i(pc), .pc_next_o(pn));
  initial forever #10 c = ~c;
  always @(posedge c) begin
    cy = cy + 1;
    // Whole run needs well under a hundred cycles
    if (cy > 2000) begin
      err_count = err_count + 1;
      summarize;
    end
  end
  task summarize;
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task ck(input string n, input [31:0] e, input [31:0] s);
    checked = checked + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // Read address of the same register driven with the write; new data shows the cycle after
  task wr(input [4:0] a, input [31:0] d, input [1:0] z, input g);
    @(negedge c); we = 1; wa = a; wd = d; sz = z; sg = g; ra = a;
    @(negedge c); v = pv; we = 0;
    @(negedge c);
  endtask
  task lv(input [1:0] n);
    @(negedge c); lw = 1; l = n;
    @(negedge c); lw = 0;
  endtask
  task t_ext;
    wr(5'h03, 32'h00000080, 2'h0, 1); ck("r3", 32'hFFFFFF80, rd);
    wr(5'h10, 32'h12348001, 2'h1, 0); ck("r16", 32'h00008001, rd);
    wr(5'h04, 32'h1234F00F, 2'h1, 1); ck("r4", 32'hFFFFF00F, rd);
    wr(5'h05, 32'h87654321, 2'h3, 1); ck("r5", 32'h87654321, rd);
  endtask
  task t_priv;
    wr(5'h18, 32'h0000AAAA, 2'h2, 0); ck("r24", 32'hAAAA, rd);
    lv(2'h3); ck("lvl", 3, lo);
    wr(5'h18, 32'h00005555, 2'h2, 0); ck("viol", 1, v);
    ck("r24", 32'hAAAA, rd);
    wr(5'h0E, 32'h00000001, 2'h2, 0); ck("viol", 1, v);
    ck("r14", 0, rd);
    wr(5'h00, 32'h00000055, 2'h2, 0); ck("viol", 0, v);
    ck("r0", 32'h55, rd);
    lv(2'h0); ck("lvl", 0, lo);
  endtask
  task t_pc;
    @(negedge c); pl = 1;
    @(negedge c); @(negedge c); pl = 0; ck("pc", 8, pc);
    rm = 1; ra = 5'h0B; @(negedge c); ck("flt", 1, f);
    ra = 5'h0F; @(negedge c); ck("flt", 1, f);
    ra = 5'h0C; @(negedge c); ck("flt", 0, f);
  endtask
  // Working register port, then a mid-run reset
  task t_wk;
    @(negedge c); kw = 1; ka = 2'h2; kd = 32'hCAFE0001; ra = 5'h02;
    @(negedge c); kw = 0;
    @(negedge c); ck("wk2", 32'hCAFE0001, wko);
    ck("r2", 0, rd);
    r = 0;
    @(negedge c); r = 1; ra = 5'h18;
    @(negedge c); ck("rst lvl", 0, lo);
    ck("rst r24", 0, rd);
    ck("rst pc", 0, pc);
    ck("rst wk", 0, wko);
  endtask
  initial begin
    repeat (5) @(negedge c);
    r = 1;
    t_ext;
    t_priv;
    t_pc;
    t_wk;
    summarize;
  end
endmodule
